// ---- triple_slave_pkg.sv ----
package triple_slave_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [4:0] CTRL_OFS = 5'h00;
    localparam logic [4:0] SA1_OFS = 5'h04;
    localparam logic [4:0] SA2_OFS = 5'h08;
    localparam logic [4:0] SA3_OFS = 5'h0c;
    localparam logic [4:0] STAT_OFS = 5'h10;
    localparam logic [4:0] PTR_OFS = 5'h14;

    // Field positions of slave_control_one.
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_PL_LSB = 1;
    localparam int CTRL_WP1_BIT = 3;
    localparam int CTRL_WP2_BIT = 4;
    localparam int CTRL_MASK_LSB = 5;
    localparam int CTRL_W = 11;

    // Field positions of the pointer register.
    localparam int PTR_CNT_LSB = 8;
    localparam int PTR_SEL_LSB = 16;

    // Reset values.
    localparam logic [10:0] CTRL_RST = 11'h000;
    localparam logic [7:0] SA_RST = 8'h00;
    localparam logic [5:0] FLAG_RST = 6'h00;

    // Fixed RAM placement of the three buffers.
    localparam int RAM_AW = 10;
    localparam logic [9:0] BUF1_BASE = 10'h100;
    localparam logic [9:0] BUF2_BASE = 10'h200;
    localparam logic [9:0] BUF3_BASE = 10'h300;

    // Rollover masks for pages and whole buffers.
    localparam logic [7:0] MASK_PAGE8 = 8'h07;
    localparam logic [7:0] MASK_PAGE16 = 8'h0f;
    localparam logic [7:0] MASK_BUF_BIG = 8'hff;
    localparam logic [7:0] MASK_BUF_S3 = 8'h7f;

    // Page length codes.
    localparam logic [1:0] PL_8 = 2'h0;
    localparam logic [1:0] PL_16 = 2'h1;

    // Bus timing at the fastest supported rate against the core clock.
    localparam int CLK_PERIOD_NS = 10;
    localparam int FAST_SCL_HIGH_NS = 600;
    localparam int FAST_SCL_HIGH_CYC = FAST_SCL_HIGH_NS / CLK_PERIOD_NS;
    localparam int SYNC_LAT_CYC = 3;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_ACK,
        S_WRX,
        S_TX,
        S_MACK,
        S_IGNORE
    } link_state_t;

endpackage

// ---- triple_slave_interface.sv ----
`timescale 1ns/1ps
// Operation
// - Slave only; never drives clock or conditions.
// - Works at standard and fast bus speed.
// - No clock stretching; RAM moves by DMA.
// - Three seven-bit addresses, each with enable.
// - Bytes MSB first; first byte is address.
// - Receiver acknowledges on ninth clock.
// - Buffers of 256, 256, 128 bytes, fixed.
// - Write protect only for slaves one, two.
// - Per slave read/write done flags, maskable.
// - Slaves one, two share irq; three separate.
// - Page length 8, 16 or full buffer.
// - Writes wrap within the current page.
// - Reads wrap over whole buffer.
// - Byte counter wraps at 256 always.
// - DMA request per received or sent byte.
// - Each DMA byte stalls CPU briefly.
// - DMA released between bytes.
// - Disabled interface returns pins to GPIO.
// - Unmatched address ignored until next start.
// - Protected writes acked but not stored.
// - Pointer advances after each written byte.
// - Sequential read continues while master acks.
module triple_slave_interface (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_i,
    // Avalon-MM register slave.
    input wire logic [4:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // Two-wire bus pins.
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe_o,
    output logic sda_o,
    output logic sda_oe_o,
    // General-purpose port drive for the pins when disabled.
    input wire logic gpio_scl_o_i,
    input wire logic gpio_scl_oe_i,
    input wire logic gpio_sda_o_i,
    input wire logic gpio_sda_oe_i,
    // DMA port to the RAM.
    output logic dma_req_o,
    output logic dma_we_o,
    output logic [triple_slave_pkg::RAM_AW-1:0] dma_addr_o,
    output logic [7:0] dma_wdata_o,
    input wire logic [7:0] dma_rdata_i,
    // Interrupt request lines.
    output logic irq12_o,
    output logic irq3_o
);
    import triple_slave_pkg::*;

    function automatic logic [2:0] match_slave(input logic [6:0] a,
                                               input logic [7:0] s1,
                                               input logic [7:0] s2,
                                               input logic [7:0] s3);
        logic [2:0] r;
        r = 3'h0;
        if (s1[0] && s1[7:1] == a) begin
            r = 3'h4;
        end else if (s2[0] && s2[7:1] == a) begin
            r = 3'h5;
        end else if (s3[0] && s3[7:1] == a) begin
            r = 3'h6;
        end
        return r;
    endfunction

    function automatic logic [7:0] wrap_next(input logic [7:0] p,
                                             input logic [7:0] m);
        logic [7:0] inc;
        inc = 8'(p + 8'h01);
        return (p & ~m) | (inc & m);
    endfunction

    function automatic logic [7:0] buf_mask(input logic [1:0] sel);
        return (sel == 2'h2) ? MASK_BUF_S3 : MASK_BUF_BIG;
    endfunction

    // Pin synchronisers and edge finders.
    logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    // Sync latency of a few cycles stays far inside a fast-mode high time.
    assign scl_rise = scl_s_q & ~scl_p_q;
    assign scl_fall = ~scl_s_q & scl_p_q;
    assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    // Register state.
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [7:0] sa_q [3];
    logic [7:0] sa_d [3];
    logic [5:0] flag_q, flag_d, flag_set;
    logic irq12_q, irq12_d, irq3_q, irq3_d;
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic enable, prot;
    logic [1:0] pl;

    // Link and DMA state.
    link_state_t state_q, state_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] shift_q, shift_d, txbuf_q, txbuf_d;
    logic [7:0] ptr_q, ptr_d, cnt_q, cnt_d;
    logic [1:0] sel_q, sel_d;
    logic rw_q, rw_d, first_q, first_d, drive_q, drive_d;
    logic wrote_q, wrote_d, read_q, read_d, fetch_q, fetch_d;
    logic dreq_q, dreq_d, dwe_q, dwe_d;
    logic [RAM_AW-1:0] daddr_q, daddr_d;
    logic [7:0] dwdata_q, dwdata_d;
    logic [2:0] hit;
    logic [7:0] wmask;

    assign enable = ctrl_q[CTRL_EN_BIT];
    assign pl = ctrl_q[CTRL_PL_LSB +: 2];
    // Only the two big buffers carry a protect bit.
    assign prot = (sel_q == 2'h0) ? ctrl_q[CTRL_WP1_BIT] :
                  (sel_q == 2'h1) ? ctrl_q[CTRL_WP2_BIT] : 1'b0;
    assign wmask = (pl == PL_8) ? MASK_PAGE8 :
                   (pl == PL_16) ? MASK_PAGE16 : buf_mask(sel_q);
    assign hit = match_slave(shift_q[7:1], sa_q[0], sa_q[1], sa_q[2]);

    function automatic logic [RAM_AW-1:0] ram_addr(input logic [1:0] sel,
                                                   input logic [7:0] p);
        logic [RAM_AW-1:0] a;
        a = BUF1_BASE + {2'h0, p};
        if (sel == 2'h1) begin
            a = BUF2_BASE + {2'h0, p};
        end else if (sel == 2'h2) begin
            a = BUF3_BASE + {3'h0, p[6:0]};
        end
        return a;
    endfunction

    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        shift_d = shift_q;
        txbuf_d = fetch_q ? dma_rdata_i : txbuf_q;
        ptr_d = ptr_q;
        cnt_d = cnt_q;
        sel_d = sel_q;
        rw_d = rw_q;
        first_d = first_q;
        drive_d = drive_q;
        wrote_d = wrote_q;
        read_d = read_q;
        fetch_d = 1'b0;
        dreq_d = 1'b0;
        dwe_d = 1'b0;
        daddr_d = daddr_q;
        dwdata_d = dwdata_q;
        flag_set = 6'h00;
        if (!enable) begin
            state_d = S_IDLE;
            drive_d = 1'b0;
            wrote_d = 1'b0;
            read_d = 1'b0;
        end else if (start_det || stop_det) begin
            // A restart closes the previous operation just as a stop does.
            flag_set[{sel_q, 1'b1}] = wrote_q;
            flag_set[{sel_q, 1'b0}] = read_q;
            wrote_d = 1'b0;
            read_d = 1'b0;
            drive_d = 1'b0;
            bit_d = 4'h0;
            state_d = start_det ? S_ADDR : S_IDLE;
        end else begin
            case (state_q)
                S_ADDR, S_WRX: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_s_q};
                        bit_d = 4'(bit_q + 4'h1);
                    end else if (scl_fall && bit_q == 4'h8) begin
                        bit_d = 4'h0;
                        drive_d = 1'b1;
                        state_d = S_ACK;
                        if (state_q == S_ADDR) begin
                            if (!hit[2]) begin
                                drive_d = 1'b0;
                                state_d = S_IGNORE;
                            end else begin
                                sel_d = hit[1:0];
                                rw_d = shift_q[0];
                                first_d = 1'b1;
                                if (shift_q[0]) begin
                                    dreq_d = 1'b1;
                                    fetch_d = 1'b1;
                                    daddr_d = ram_addr(hit[1:0], ptr_q);
                                end
                            end
                        end else if (first_q) begin
                            first_d = 1'b0;
                            ptr_d = shift_q;
                        end else begin
                            // Protected data is acked, counted and advances the pointer, but is not stored.
                            if (!prot) begin
                                dreq_d = 1'b1;
                                dwe_d = 1'b1;
                                daddr_d = ram_addr(sel_q, ptr_q);
                                dwdata_d = shift_q;
                                wrote_d = 1'b1;
                            end
                            ptr_d = wrap_next(ptr_q, wmask);
                            cnt_d = 8'(cnt_q + 8'h01);
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        bit_d = 4'h0;
                        drive_d = 1'b0;
                        state_d = S_WRX;
                        if (rw_q) begin
                            shift_d = txbuf_q;
                            drive_d = ~txbuf_q[7];
                            state_d = S_TX;
                        end
                    end
                end
                S_TX: begin
                    if (scl_rise) begin
                        bit_d = 4'(bit_q + 4'h1);
                    end else if (scl_fall && bit_q == 4'h8) begin
                        drive_d = 1'b0;
                        state_d = S_MACK;
                        read_d = 1'b1;
                        ptr_d = wrap_next(ptr_q, buf_mask(sel_q));
                        cnt_d = 8'(cnt_q + 8'h01);
                    end else if (scl_fall) begin
                        shift_d = {shift_q[6:0], 1'b0};
                        drive_d = ~shift_q[6];
                    end
                end
                S_MACK: begin
                    if (scl_rise) begin
                        if (sda_s_q) begin
                            state_d = S_IGNORE;
                        end else begin
                            state_d = S_ACK;
                            dreq_d = 1'b1;
                            fetch_d = 1'b1;
                            daddr_d = ram_addr(sel_q, ptr_q);
                        end
                    end
                end
                default: begin
                    drive_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_q <= S_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            txbuf_q <= 8'h00;
            ptr_q <= 8'h00;
            cnt_q <= 8'h00;
            sel_q <= 2'h0;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            drive_q <= 1'b0;
            wrote_q <= 1'b0;
            read_q <= 1'b0;
            fetch_q <= 1'b0;
            dreq_q <= 1'b0;
            dwe_q <= 1'b0;
            daddr_q <= '0;
            dwdata_q <= 8'h00;
        end else begin
            state_q <= state_d;
            bit_q <= bit_d;
            shift_q <= shift_d;
            txbuf_q <= txbuf_d;
            ptr_q <= ptr_d;
            cnt_q <= cnt_d;
            sel_q <= sel_d;
            rw_q <= rw_d;
            first_q <= first_d;
            drive_q <= drive_d;
            wrote_q <= wrote_d;
            read_q <= read_d;
            fetch_q <= fetch_d;
            dreq_q <= dreq_d;
            dwe_q <= dwe_d;
            daddr_q <= daddr_d;
            dwdata_q <= dwdata_d;
        end
    end

    // Register bus; every access is answered on its second cycle.
    always_comb begin
        logic hit_rd;
        hit_rd = 1'b0;
        ctrl_d = ctrl_q;
        sa_d = sa_q;
        flag_d = flag_q | flag_set;
        ack_d = (read_i | write_i) & ~ack_q;
        rdata_d = rdata_q;
        if (write_i && ack_q) begin
            if (address_i == CTRL_OFS) begin
                ctrl_d = writedata_i[CTRL_W-1:0];
            end else if (address_i == SA1_OFS) begin
                sa_d[0] = writedata_i[7:0];
            end else if (address_i == SA2_OFS) begin
                sa_d[1] = writedata_i[7:0];
            end else if (address_i == SA3_OFS) begin
                sa_d[2] = writedata_i[7:0];
            end else if (address_i == STAT_OFS) begin
                // A hardware set in the same cycle wins over the clear.
                flag_d = (flag_q & ~writedata_i[5:0]) | flag_set;
            end
        end
        if (read_i && ack_d) begin
            hit_rd = 1'b1;
            rdata_d = 32'h0000_0000;
            if (address_i == CTRL_OFS) begin
                rdata_d[CTRL_W-1:0] = ctrl_q;
            end else if (address_i == SA1_OFS) begin
                rdata_d[7:0] = sa_q[0];
            end else if (address_i == SA2_OFS) begin
                rdata_d[7:0] = sa_q[1];
            end else if (address_i == SA3_OFS) begin
                rdata_d[7:0] = sa_q[2];
            end else if (address_i == STAT_OFS) begin
                rdata_d[5:0] = flag_q;
            end else if (address_i == PTR_OFS) begin
                rdata_d[7:0] = ptr_q;
                rdata_d[PTR_CNT_LSB +: 8] = cnt_q;
                rdata_d[PTR_SEL_LSB +: 2] = sel_q;
            end
        end
        irq12_d = |(flag_d[3:0] & ctrl_q[CTRL_MASK_LSB +: 4]);
        irq3_d = |(flag_d[5:4] & ctrl_q[CTRL_MASK_LSB+4 +: 2]);
        if (!hit_rd) begin
            rdata_d = rdata_q;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
            sa_q <= '{SA_RST, SA_RST, SA_RST};
            flag_q <= FLAG_RST;
            irq12_q <= 1'b0;
            irq3_q <= 1'b0;
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            sa_q <= sa_d;
            flag_q <= flag_d;
            irq12_q <= irq12_d;
            irq3_q <= irq3_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    assign waitrequest_o = (read_i | write_i) & ~ack_q;
    assign readdata_o = rdata_q;
    assign irq12_o = irq12_q;
    assign irq3_o = irq3_q;
    assign dma_req_o = dreq_q;
    assign dma_we_o = dwe_q;
    assign dma_addr_o = daddr_q;
    assign dma_wdata_o = dwdata_q;
    // The clock pin is never driven while enabled; no stretching at all.
    assign scl_oe_o = enable ? 1'b0 : gpio_scl_oe_i;
    assign scl_o = enable ? 1'b0 : gpio_scl_o_i;
    assign sda_oe_o = enable ? drive_q : gpio_sda_oe_i;
    assign sda_o = enable ? 1'b0 : gpio_sda_o_i;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_data_end;
        state_q == S_WRX && scl_fall && bit_q == 4'h8 && !first_q;
    endsequence
    sequence s_tx_end;
        state_q == S_TX && scl_fall && bit_q == 4'h8 && enable;
    endsequence
    sequence s_nack;
        state_q == S_MACK && scl_rise && sda_s_q && enable;
    endsequence

    property p_no_scl;
        enable |-> !scl_oe_o;
    endproperty
    a_no_scl: assert property (p_no_scl)
        else $error("Clock pin driven while enabled.");

    property p_gpio;
        !enable |-> sda_oe_o == gpio_sda_oe_i && sda_o == gpio_sda_o_i;
    endproperty
    a_gpio: assert property (p_gpio)
        else $error("Data pin not returned to port use.");

    property p_ack;
        state_q == S_ADDR && scl_fall && bit_q == 4'h8 && hit[2] && enable
            && !start_det && !stop_det |=> sda_oe_o && !sda_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("Matched address not acknowledged.");

    property p_nomatch;
        state_q == S_ADDR && scl_fall && bit_q == 4'h8 && !hit[2] && enable
            && !start_det && !stop_det |=> state_q == S_IGNORE && !drive_q;
    endproperty
    a_nomatch: assert property (p_nomatch)
        else $error("Unmatched address not ignored.");

    property p_rx_dma;
        s_data_end and (!prot && enable && !start_det && !stop_det)
            |=> dma_req_o && dma_we_o && dma_wdata_o == $past(shift_q);
    endproperty
    a_rx_dma: assert property (p_rx_dma)
        else $error("Received byte not sent to RAM.");

    property p_protect;
        dma_req_o && dma_we_o |-> !prot;
    endproperty
    a_protect: assert property (p_protect)
        else $error("Protected buffer written.");

    property p_dma_release;
        dma_req_o |=> !dma_req_o;
    endproperty
    a_dma_release: assert property (p_dma_release)
        else $error("DMA held the RAM across bytes.");

    property p_page8;
        s_data_end and (pl == PL_8 && enable && !start_det && !stop_det)
            |=> ptr_q[7:3] == $past(ptr_q[7:3])
                && ptr_q[2:0] == 3'($past(ptr_q[2:0]) + 3'h1);
    endproperty
    a_page8: assert property (p_page8)
        else $error("Write pointer left its page.");

    property p_count;
        s_data_end and (enable && !start_det && !stop_det)
            |=> cnt_q == 8'($past(cnt_q) + 8'h01);
    endproperty
    a_count: assert property (p_count)
        else $error("Byte count not advanced modulo 256.");

    property p_read_wrap;
        s_tx_end and (sel_q == 2'h2 && !start_det && !stop_det)
            |=> ptr_q[6:0] == 7'($past(ptr_q[6:0]) + 7'h01);
    endproperty
    a_read_wrap: assert property (p_read_wrap)
        else $error("Read pointer not wrapped over buffer.");

    property p_nack;
        s_nack and (!start_det && !stop_det) |=> state_q == S_IGNORE ##1
            !drive_q;
    endproperty
    a_nack: assert property (p_nack)
        else $error("Slave kept sending after a nack.");

    // The line is registered from the next flag value, so it already
    // follows a standing flag; a mask change needs one cycle to show.
    property p_irq;
        flag_q[4] && ctrl_q[CTRL_MASK_LSB+4] && $stable(ctrl_q) |-> irq3_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("Unmasked flag gave no interrupt.");

endmodule // triple_slave_interface

// ---- bus_master_model.sv ----
`timescale 1ns/1ps
module bus_master_model (
    // Open-drain lines; a high output pulls the line low.
    input wire logic sda_i,
    output logic scl_low_o,
    output logic sda_low_o
);
    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end
    // The clock is left released, so it stands high between frames.
    task automatic start_cond;
        sda_low_o = 1'b0;
        #40 scl_low_o = 1'b0;
        #80 sda_low_o = 1'b1;
        #80 scl_low_o = 1'b1;
        #40;
    endtask
    task automatic stop_cond;
        sda_low_o = 1'b1;
        #40 scl_low_o = 1'b0;
        #80 sda_low_o = 1'b0;
        #80;
    endtask
    // Data moves mid-low so it is steady around both clock edges.
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_low_o = ~tx[i];
            #40 scl_low_o = 1'b0;
            #80 rx[i] = sda_i;
            scl_low_o = 1'b1;
            #40;
        end
    endtask
endmodule // bus_master_model

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import triple_slave_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [4:0] address_i = 5'h00;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0;
    logic [31:0] readdata_o, q;
    logic waitrequest_o, scl_o, scl_oe_o, sda_o, sda_oe_o;
    logic dma_req_o, dma_we_o, irq12_o, irq3_o, scl_low, sda_low;
    logic bus_on = 1'b0;
    logic [3:0] gpio = 4'h0;
    logic [9:0] dma_addr_o;
    logic [7:0] dma_wdata_o;
    logic [7:0] dma_rdata_i;
    logic [7:0] ram [1024];
    logic [7:0] d [3];
    logic [8:0] rx;
    int err_count = 0, cmp_count = 0, cyc = 0, run = 0;
    wire scl = ~scl_low & (scl_oe_o ? scl_o : 1'b1);
    wire sda = ~sda_low & (sda_oe_o ? sda_o : 1'b1);

    always #5 clock_i = ~clock_i;

    triple_slave_interface i_triple_slave_interface (
        .clock_i(clock_i), .rst_i(rst_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .scl_i(scl), .sda_i(sda), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .gpio_scl_o_i(gpio[3]),
        .gpio_scl_oe_i(gpio[2]), .gpio_sda_o_i(gpio[1]),
        .gpio_sda_oe_i(gpio[0]), .dma_req_o(dma_req_o),
        .dma_we_o(dma_we_o), .dma_addr_o(dma_addr_o),
        .dma_wdata_o(dma_wdata_o), .dma_rdata_i(dma_rdata_i),
        .irq12_o(irq12_o), .irq3_o(irq3_o));
    bus_master_model i_bus_master_model (
        .sda_i(sda), .scl_low_o(scl_low), .sda_low_o(sda_low));

    task automatic chk(input logic [31:0] g, input logic [31:0] e, string m);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    function automatic logic [9:0] page_ofs(input int p, input int i);
        int o;
        o = 126 + i;
        return 10'((p == 1) ? 112 + o % 16 : o % 128);
    endfunction
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [4:0] a, logic [31:0] v);
        @(posedge clock_i);
        address_i <= a;
        writedata_i <= v;
        write_i <= w;
        read_i <= ~w;
        do @(posedge clock_i); while (waitrequest_o !== 1'b0);
        q = readdata_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
    endtask
    task automatic wb(input logic [7:0] b, input logic ack);
        i_bus_master_model.xfer({b, 1'b1}, rx);
        chk(rx[0], !ack, "byte ack");
    endtask
    task automatic fin(input string m);
        i_bus_master_model.stop_cond;
        repeat (20) @(posedge clock_i);
        $display("test %s done", m);
    endtask

    // RAM side of the DMA port; the slave takes read data in the request
    // cycle, so the model answers without a register stage.
    assign dma_rdata_i = ram[dma_addr_o];
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        run <= dma_req_o ? run + 1 : 0;
        if (dma_req_o && dma_we_o) ram[dma_addr_o] <= dma_wdata_o;
        if (run > 2) chk(0, 1, "dma held");
        if (bus_on && scl_oe_o !== 1'b0) chk(0, 1, "clock driven");
        if (cyc == 50000) begin
            err_count++;
            test_done;
        end
    end

    initial begin
        q = $urandom(21);
        foreach (ram[i]) ram[i] = 8'($urandom);
        @(posedge clock_i);
        gpio <= 4'($urandom);
        repeat (19) @(posedge clock_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            acc(1'b0, 5'(i * 4), 32'h0);
            chk(q, 32'h0, "reset value");
        end
        chk({scl_o, scl_oe_o, sda_o, sda_oe_o}, gpio, "port pins");
        $display("test reset done");
        acc(1'b1, SA1_OFS, 32'ha1);
        acc(1'b1, SA2_OFS, 32'ha3);
        acc(1'b1, SA3_OFS, 32'ha5);
        acc(1'b1, CTRL_OFS, 32'h7f1);
        acc(1'b0, CTRL_OFS, 32'h0);
        chk(q, 32'h7f1, "control");
        bus_on <= 1'b1;
        foreach (d[i]) d[i] = 8'($urandom);
        i_bus_master_model.start_cond;
        wb(8'ha0, 1'b1);
        wb(8'h06, 1'b1);
        foreach (d[i]) wb(d[i], 1'b1);
        fin("page write");
        foreach (d[i])
            chk(ram[BUF1_BASE + 10'((6 + i) % 8)], d[i], "ram");
        acc(1'b0, PTR_OFS, 32'h0);
        chk(q[7:0], 8'h01, "pointer");
        acc(1'b0, STAT_OFS, 32'h0);
        chk(q, 32'h2, "write flag");
        chk({irq12_o, irq3_o}, 2'b10, "irq");
        acc(1'b1, STAT_OFS, 32'h3f);
        acc(1'b0, STAT_OFS, 32'h0);
        chk(irq12_o, 1'b0, "irq clear");
        d[0] = ~ram[10'h210];
        i_bus_master_model.start_cond;
        wb(8'ha2, 1'b1);
        wb(8'h10, 1'b1);
        wb(d[0], 1'b1);
        fin("protect");
        chk(ram[10'h210], 8'(~d[0]), "protected");
        acc(1'b0, STAT_OFS, 32'h0);
        chk(q, 32'h0, "no flag");
        i_bus_master_model.start_cond;
        wb(8'ha4, 1'b1);
        wb(8'h7f, 1'b1);
        i_bus_master_model.start_cond;
        wb(8'ha5, 1'b1);
        i_bus_master_model.xfer(9'h1fe, rx);
        chk(rx[8:1], ram[10'h37f], "read");
        i_bus_master_model.xfer(9'h1ff, rx);
        chk(rx[8:1], ram[10'h300], "read wrap");
        i_bus_master_model.xfer(9'h1ff, rx);
        chk(rx[8:1], 8'hff, "released");
        fin("read");
        acc(1'b0, STAT_OFS, 32'h0);
        chk(q, 32'h10, "read flag");
        chk({irq12_o, irq3_o}, 2'b01, "irq3");
        foreach (d[i]) d[i] = 8'($urandom);
        for (int p = 1; p < 3; p++) begin
            acc(1'b1, CTRL_OFS, 32'h7f1 | 32'(p * 2));
            i_bus_master_model.start_cond;
            wb(8'ha4, 1'b1);
            wb(8'h7e, 1'b1);
            foreach (d[i]) wb(d[i], 1'b1);
            fin("page select");
            foreach (d[i])
                chk(ram[BUF3_BASE + page_ofs(p, i)], d[i], "page");
        end
        i_bus_master_model.start_cond;
        wb(8'h66, 1'b0);
        wb(8'ha0, 1'b0);
        fin("no match");
        bus_on <= 1'b0;
        acc(1'b1, CTRL_OFS, 32'h0);
        gpio <= 4'($urandom);
        @(negedge clock_i);
        chk({scl_o, scl_oe_o, sda_o, sda_oe_o}, gpio, "port pins");
        $display("test disable done");
        test_done;
    end
endmodule // testbench
